// >>> rtl/igl_check.sv
/*
 * igl_check: classifies a load before it starts: how many words it moves,
 * whether its destination is legal and whether its address is misaligned.
 * assumes the operation has already been decoded from the opcode.
 */
`timescale 1ns/1ps
module igl_check (
	input wire igl_pkg::igl_op_t op_i,
	input wire logic [4:0] dst_i,
	input wire logic [31:0] addr_i,
	input wire logic unal_fault_en_i,
	output logic [2:0] words_o,
	output logic bad_dst_o,
	output logic unaligned_o
);

	// word count, register alignment and address alignment per variant
	always_comb
	begin
		words_o = 3'h1;
		bad_dst_o = 1'b0;
		unaligned_o = 1'b0;
		case (op_i)
			igl_pkg::IGL_OP_LOAD_SINGLE_WORD:
				unaligned_o = unal_fault_en_i && (addr_i[1:0] != 2'h0); // RULE15
			igl_pkg::IGL_OP_LOAD_UHALF, igl_pkg::IGL_OP_LOAD_SHALF:
				unaligned_o = unal_fault_en_i && addr_i[0];
			igl_pkg::IGL_OP_LOAD_DOUBLE_WORD:
			begin
				words_o = 3'h2; // RULE11
				bad_dst_o = dst_i[0]; // RULE14
				unaligned_o = unal_fault_en_i && (addr_i[2:0] != 3'h0); // RULE16
			end
			igl_pkg::IGL_OP_LOAD_TRIPLE_WORD:
			begin
				words_o = 3'h3; // RULE11
				bad_dst_o = (dst_i[1:0] != 2'h0); // RULE14
				unaligned_o = unal_fault_en_i && (addr_i[3:0] != 4'h0); // RULE16
			end
			igl_pkg::IGL_OP_LOAD_QUAD_WORD:
			begin
				words_o = 3'h4; // RULE11
				bad_dst_o = (dst_i[1:0] != 2'h0); // RULE14
				unaligned_o = unal_fault_en_i && (addr_i[3:0] != 4'h0); // RULE16
			end
			default:
				words_o = 3'h1;
		endcase
	end

endmodule

// >>> rtl/igl_exec_unit.sv
/*
 * igl_exec_unit: executes the global interrupt gate instructions and the
 * memory load family for one issued instruction at a time.
 * assumes the pipeline holds a command until busy_o is low, the memory
 * answers each held request with exactly one mem_ack_i pulse, and the
 * register file takes one write per cycle from wb_o.
 * the unaligned-address fault of a load is reported after its registers were written.
 *
// Summary of operation
// RULE1: disable instruction sets mask bit to one
// RULE2: enable instruction clears mask bit to zero
// RULE3: non-supervisor gate instruction raises privilege fault
// RULE4: mask zero enables, mask one disables interrupts
// RULE5: control operand 0,1,2 valid, else operand fault
// RULE6: control writes prior enable state to destination
// RULE7: load from address into destination and followers
// RULE8: byte/half loads sign or zero extend
// RULE9: unsigned byte load zeroes bits 31:8
// RULE10: signed byte load copies bit 7 upward
// RULE11: word loads move 4,8,12,16 bytes
// RULE12: software names even register for double loads
// RULE13: software names multiple-of-four register for triple/quad
// RULE14: misaligned destination register faults, nothing written
// RULE15: misaligned single-word address faults when enabled
// RULE16: misaligned double/triple/quad address faults when enabled
 */
`timescale 1ns/1ps
module igl_exec_unit (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic cmd_valid_i,
	input wire igl_pkg::igl_cmd_t cmd_i,
	output logic busy_o,
	output logic mem_req_o,
	output logic [31:0] mem_addr_o,
	input wire logic mem_ack_i,
	input wire logic [31:0] mem_rdata_i,
	output igl_pkg::igl_wb_t wb_o,
	output logic done_o,
	output igl_pkg::igl_fault_t fault_o,
	output logic irq_mask_o
);

	// whole state of the unit lives in one record
	typedef struct packed {
		igl_pkg::igl_state_t state;
		logic mask;
		igl_pkg::igl_op_t op;
		logic [4:0] dst;
		logic [31:0] addr;
		logic [2:0] beat;
		logic [2:0] words;
		logic unal_pend;
		logic mem_req;
		igl_pkg::igl_wb_t wb;
		logic done;
		igl_pkg::igl_fault_t fault;
		logic busy;
	} igl_regs_t;

	igl_regs_t st_r;
	igl_regs_t st_nxt;
	igl_pkg::igl_op_t cmd_op;
	logic [2:0] chk_words;
	logic chk_bad_dst;
	logic chk_unaligned;
	logic [31:0] ext_data;
	logic beat_last;
	logic cmd_take;
	logic prior_en;

	// opcode to operation; memory-format opcodes use the upper eight bits
	function automatic igl_pkg::igl_op_t igl_decode(input logic [11:0] opc);
		igl_pkg::igl_op_t op;
		op = igl_pkg::IGL_OP_NONE;
		if (opc == igl_pkg::IGL_OPC_IRQ_CONTROL)
			op = igl_pkg::IGL_OP_IRQ_CONTROL;
		else if (opc == igl_pkg::IGL_OPC_IRQ_DISABLE)
			op = igl_pkg::IGL_OP_IRQ_DISABLE;
		else if (opc == igl_pkg::IGL_OPC_IRQ_ENABLE)
			op = igl_pkg::IGL_OP_IRQ_ENABLE;
		else
		begin
			case (opc[11:4])
				igl_pkg::IGL_OPC_LOAD_SINGLE_WORD: op = igl_pkg::IGL_OP_LOAD_SINGLE_WORD;
				igl_pkg::IGL_OPC_LOAD_UBYTE: op = igl_pkg::IGL_OP_LOAD_UBYTE;
				igl_pkg::IGL_OPC_LOAD_UHALF: op = igl_pkg::IGL_OP_LOAD_UHALF;
				igl_pkg::IGL_OPC_LOAD_SBYTE: op = igl_pkg::IGL_OP_LOAD_SBYTE;
				igl_pkg::IGL_OPC_LOAD_SHALF: op = igl_pkg::IGL_OP_LOAD_SHALF;
				igl_pkg::IGL_OPC_LOAD_DOUBLE_WORD: op = igl_pkg::IGL_OP_LOAD_DOUBLE_WORD;
				igl_pkg::IGL_OPC_LOAD_TRIPLE_WORD: op = igl_pkg::IGL_OP_LOAD_TRIPLE_WORD;
				igl_pkg::IGL_OPC_LOAD_QUAD_WORD: op = igl_pkg::IGL_OP_LOAD_QUAD_WORD;
				default: op = igl_pkg::IGL_OP_NONE;
			endcase
		end
		return op;
	endfunction

	// true for the three interrupt gate instructions
	function automatic logic igl_is_gate(input igl_pkg::igl_op_t op);
		return (op == igl_pkg::IGL_OP_IRQ_CONTROL) || (op == igl_pkg::IGL_OP_IRQ_DISABLE) ||
			(op == igl_pkg::IGL_OP_IRQ_ENABLE);
	endfunction

	// legal first operand of the interrupt control instruction
	function automatic logic igl_ctl_ok(input logic [31:0] src1);
		return (src1 == igl_pkg::IGL_SRC1_DISABLE) || (src1 == igl_pkg::IGL_SRC1_ENABLE) ||
			(src1 == igl_pkg::IGL_SRC1_STATUS);
	endfunction

	// fault record of a valid bit and a fault code, used at every completion point
	function automatic igl_pkg::igl_fault_t igl_fault(input igl_pkg::igl_fault_code_t code);
		igl_pkg::igl_fault_t f;
		f.valid = (code != igl_pkg::IGL_FLT_NONE);
		f.code = code;
		return f;
	endfunction

	assign cmd_op = igl_decode(cmd_i.opcode);
	assign beat_last = ((st_r.beat + 3'h1) == st_r.words);
	// commands are looked at only in idle; one offered while busy is dropped, not queued
	assign cmd_take = cmd_valid_i && (st_r.state == igl_pkg::IGL_ST_IDLE);
	// enable state before this instruction, inverted from the mask polarity
	assign prior_en = (st_r.mask == igl_pkg::IGL_MASK_ON); // RULE4 RULE6

	// load classification from the issued command
	igl_check u_check (
		.op_i(cmd_op),
		.dst_i(cmd_i.dst),
		.addr_i(cmd_i.addr),
		.unal_fault_en_i(cmd_i.unal_fault_en),
		.words_o(chk_words),
		.bad_dst_o(chk_bad_dst),
		.unaligned_o(chk_unaligned)
	);

	// widening of each returned word for the active variant
	igl_extend u_extend (
		.op_i(st_r.op),
		.word_i(mem_rdata_i),
		.data_o(ext_data)
	);

	// next-state logic; single-cycle strobes fall back to idle values
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.wb.en = 1'b0;
		st_nxt.done = 1'b0;
		st_nxt.fault = igl_fault(igl_pkg::IGL_FLT_NONE);
		// writes and completion appear one cycle after their cause, straight from the register
		case (st_r.state)
			igl_pkg::IGL_ST_IDLE:
			begin
				if (cmd_take)
				begin
					st_nxt.op = cmd_op;
					st_nxt.dst = cmd_i.dst;
					st_nxt.addr = cmd_i.addr;
					st_nxt.beat = 3'h0;
					st_nxt.words = chk_words;
					st_nxt.unal_pend = chk_unaligned;
					if (cmd_op == igl_pkg::IGL_OP_NONE)
					begin
						// unknown opcodes finish at once with their own fault
						st_nxt.done = 1'b1;
						st_nxt.fault = igl_fault(igl_pkg::IGL_FLT_OPCODE);
					end
					else if (igl_is_gate(cmd_op))
					begin
						// privilege is judged before the operand, so a user never moves the mask
						if (!cmd_i.supervisor)
						begin
							st_nxt.done = 1'b1; // RULE3
							st_nxt.fault = igl_fault(igl_pkg::IGL_FLT_PRIVILEGE); // RULE3
						end
						else if (cmd_op == igl_pkg::IGL_OP_IRQ_DISABLE)
						begin
							st_nxt.mask = igl_pkg::IGL_MASK_OFF; // RULE1 RULE4
							st_nxt.busy = 1'b1;
							st_nxt.state = igl_pkg::IGL_ST_ORDER; // RULE1
						end
						else if (cmd_op == igl_pkg::IGL_OP_IRQ_ENABLE)
						begin
							st_nxt.mask = igl_pkg::IGL_MASK_ON; // RULE2 RULE4
							st_nxt.busy = 1'b1;
							st_nxt.state = igl_pkg::IGL_ST_ORDER; // RULE2
						end
						else if (igl_ctl_ok(cmd_i.src1)) // RULE5
						begin
							// prior state is captured before the mask moves
							st_nxt.wb.en = 1'b1; // RULE6
							st_nxt.wb.idx = cmd_i.dst;
							st_nxt.wb.data = {31'h0, prior_en}; // RULE6 RULE4
							if (cmd_i.src1 == igl_pkg::IGL_SRC1_DISABLE)
								st_nxt.mask = igl_pkg::IGL_MASK_OFF; // RULE5 RULE1
							else if (cmd_i.src1 == igl_pkg::IGL_SRC1_ENABLE)
								st_nxt.mask = igl_pkg::IGL_MASK_ON; // RULE5 RULE2
							st_nxt.busy = 1'b1;
							st_nxt.state = igl_pkg::IGL_ST_ORDER;
						end
						else
						begin
							st_nxt.done = 1'b1; // RULE5
							st_nxt.fault = igl_fault(igl_pkg::IGL_FLT_OPERAND); // RULE5
						end
					end
					else if (chk_bad_dst)
					begin
						// no memory access and no register write
						st_nxt.done = 1'b1; // RULE14
						st_nxt.fault = igl_fault(igl_pkg::IGL_FLT_OPERAND); // RULE14
					end
					else
					begin
						st_nxt.mem_req = 1'b1; // RULE7
						st_nxt.busy = 1'b1;
						st_nxt.state = igl_pkg::IGL_ST_READ;
					end
				end
			end
			igl_pkg::IGL_ST_ORDER:
			begin
				// one cycle with the new mask visible before completion
				st_nxt.done = 1'b1; // RULE1 RULE2
				st_nxt.busy = 1'b0;
				st_nxt.state = igl_pkg::IGL_ST_IDLE;
			end
			igl_pkg::IGL_ST_ISSUE:
			begin
				// request drops for a cycle between beats so each ack pairs with one beat
				st_nxt.mem_req = 1'b1;
				st_nxt.state = igl_pkg::IGL_ST_READ;
			end
			igl_pkg::IGL_ST_READ:
			begin
				// address steps only on an accepted beat, so a slow memory sees it stable
				if (mem_ack_i)
				begin
					st_nxt.mem_req = 1'b0;
					st_nxt.wb.en = 1'b1; // RULE7
					st_nxt.wb.idx = st_r.dst + {2'h0, st_r.beat}; // RULE7 RULE11
					st_nxt.wb.data = ext_data; // RULE8
					st_nxt.beat = st_r.beat + 3'h1;
					st_nxt.addr = st_r.addr + igl_pkg::IGL_WORD_STEP; // RULE11
					if (beat_last)
						st_nxt.state = igl_pkg::IGL_ST_FINISH;
					else
						st_nxt.state = igl_pkg::IGL_ST_ISSUE;
				end
			end
			igl_pkg::IGL_ST_FINISH:
			begin
				// misalignment is reported after the data has landed
				st_nxt.done = 1'b1;
				if (st_r.unal_pend)
					st_nxt.fault = igl_fault(igl_pkg::IGL_FLT_UNALIGNED); // RULE15 RULE16
				st_nxt.busy = 1'b0;
				st_nxt.state = igl_pkg::IGL_ST_IDLE;
			end
			default:
			begin
				// an unreachable state falls back to idle with no request left standing
				st_nxt.state = igl_pkg::IGL_ST_IDLE;
				st_nxt.busy = 1'b0;
				st_nxt.mem_req = 1'b0;
			end
		endcase
	end

	// state register with synchronous reset
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			st_r.state <= igl_pkg::IGL_ST_IDLE;
			st_r.mask <= igl_pkg::IGL_MASK_RST; // RULE4
			st_r.op <= igl_pkg::IGL_OP_NONE;
			st_r.dst <= 5'h00;
			st_r.addr <= 32'h0000_0000;
			st_r.beat <= 3'h0;
			st_r.words <= 3'h0;
			st_r.unal_pend <= 1'b0;
			st_r.mem_req <= 1'b0;
			st_r.wb <= '0;
			st_r.done <= 1'b0;
			st_r.fault <= igl_fault(igl_pkg::IGL_FLT_NONE);
			st_r.busy <= 1'b0;
		end
		else
			st_r <= st_nxt;
	end

	// every output is a field of the state register
	assign busy_o = st_r.busy;
	assign mem_req_o = st_r.mem_req;
	assign mem_addr_o = st_r.addr;
	assign wb_o = st_r.wb;
	assign done_o = st_r.done;
	assign fault_o = st_r.fault;
	assign irq_mask_o = st_r.mask; // RULE4

endmodule

// >>> rtl/igl_extend.sv
/*
 * igl_extend: widens a fetched memory word to a register value according
 * to the load variant.
 * assumes the first byte at the address sits in bits 7:0 of the word.
 */
`timescale 1ns/1ps
module igl_extend (
	input wire igl_pkg::igl_op_t op_i,
	input wire logic [31:0] word_i,
	output logic [31:0] data_o
);

	// byte and half loads widen by sign or zero, words pass through
	always_comb
	begin
		case (op_i)
			igl_pkg::IGL_OP_LOAD_UBYTE:
				data_o = {igl_pkg::IGL_FILL_BYTE_ZERO, word_i[7:0]}; // RULE8 RULE9
			igl_pkg::IGL_OP_LOAD_SBYTE:
				if (word_i[igl_pkg::IGL_BYTE_SIGN_POS])
					data_o = {igl_pkg::IGL_FILL_BYTE_ONES, word_i[7:0]}; // RULE10
				else
					data_o = {igl_pkg::IGL_FILL_BYTE_ZERO, word_i[7:0]}; // RULE10
			igl_pkg::IGL_OP_LOAD_UHALF:
				data_o = {igl_pkg::IGL_FILL_HALF_ZERO, word_i[15:0]}; // RULE8
			igl_pkg::IGL_OP_LOAD_SHALF:
				if (word_i[igl_pkg::IGL_HALF_SIGN_POS])
					data_o = {igl_pkg::IGL_FILL_HALF_ONES, word_i[15:0]}; // RULE8
				else
					data_o = {igl_pkg::IGL_FILL_HALF_ZERO, word_i[15:0]}; // RULE8
			default:
				data_o = word_i;
		endcase
	end

endmodule

// >>> rtl/igl_pkg.sv
/*
 * igl_pkg: shared constants, encodings and carrier types for the interrupt
 * gate and load execute unit.
 * assumes a single processor clock and a word-wide memory read port.
 */
package igl_pkg;

	// instruction encodings, 12-bit register-format opcodes
	localparam logic [11:0] IGL_OPC_IRQ_CONTROL = 12'h658;
	localparam logic [11:0] IGL_OPC_IRQ_DISABLE = 12'h5b4;
	localparam logic [11:0] IGL_OPC_IRQ_ENABLE = 12'h5b5;

	// 8-bit memory-format opcodes, carried in opcode bits 11:4
	localparam logic [7:0] IGL_OPC_LOAD_SINGLE_WORD = 8'h90;
	localparam logic [7:0] IGL_OPC_LOAD_UBYTE = 8'h80;
	localparam logic [7:0] IGL_OPC_LOAD_UHALF = 8'h88;
	localparam logic [7:0] IGL_OPC_LOAD_SBYTE = 8'hc0;
	localparam logic [7:0] IGL_OPC_LOAD_SHALF = 8'hc8;
	localparam logic [7:0] IGL_OPC_LOAD_DOUBLE_WORD = 8'h98;
	localparam logic [7:0] IGL_OPC_LOAD_TRIPLE_WORD = 8'ha0;
	localparam logic [7:0] IGL_OPC_LOAD_QUAD_WORD = 8'hb0;

	// interrupt control operand values
	localparam logic [31:0] IGL_SRC1_DISABLE = 32'h0000_0000;
	localparam logic [31:0] IGL_SRC1_ENABLE = 32'h0000_0001;
	localparam logic [31:0] IGL_SRC1_STATUS = 32'h0000_0002;

	// mask bit polarity: one means interrupts are held off
	localparam logic IGL_MASK_OFF = 1'b1;
	localparam logic IGL_MASK_ON = 1'b0;
	localparam logic IGL_MASK_RST = 1'b1;

	// extension fill patterns and field positions
	localparam logic [23:0] IGL_FILL_BYTE_ZERO = 24'h000000;
	localparam logic [23:0] IGL_FILL_BYTE_ONES = 24'hffffff;
	localparam logic [15:0] IGL_FILL_HALF_ZERO = 16'h0000;
	localparam logic [15:0] IGL_FILL_HALF_ONES = 16'hffff;
	localparam int IGL_BYTE_SIGN_POS = 7;
	localparam int IGL_HALF_SIGN_POS = 15;

	// address step between consecutive words of a multi-word load
	localparam logic [31:0] IGL_WORD_STEP = 32'h0000_0004;

	typedef enum logic [3:0] {
		IGL_OP_NONE,
		IGL_OP_IRQ_CONTROL,
		IGL_OP_IRQ_DISABLE,
		IGL_OP_IRQ_ENABLE,
		IGL_OP_LOAD_SINGLE_WORD,
		IGL_OP_LOAD_UBYTE,
		IGL_OP_LOAD_UHALF,
		IGL_OP_LOAD_SBYTE,
		IGL_OP_LOAD_SHALF,
		IGL_OP_LOAD_DOUBLE_WORD,
		IGL_OP_LOAD_TRIPLE_WORD,
		IGL_OP_LOAD_QUAD_WORD
	} igl_op_t;

	typedef enum logic [2:0] {
		IGL_FLT_NONE,
		IGL_FLT_PRIVILEGE,
		IGL_FLT_OPERAND,
		IGL_FLT_UNALIGNED,
		IGL_FLT_OPCODE
	} igl_fault_code_t;

	typedef enum {
		IGL_ST_IDLE,
		IGL_ST_ORDER,
		IGL_ST_ISSUE,
		IGL_ST_READ,
		IGL_ST_FINISH
	} igl_state_t;

	typedef struct packed {
		logic [11:0] opcode;
		logic [31:0] src1;
		logic [4:0] dst;
		logic [31:0] addr;
		logic supervisor;
		logic unal_fault_en;
	} igl_cmd_t;

	typedef struct packed {
		logic en;
		logic [4:0] idx;
		logic [31:0] data;
	} igl_wb_t;

	typedef struct packed {
		logic valid;
		igl_fault_code_t code;
	} igl_fault_t;

endpackage

// >>> tb/igl_exec_unit_sva.sv
/*
 * igl_exec_unit_sva: timing checks on the exec unit ports.
 * assumes one clock domain and the synchronous reset of the unit.
 */
`timescale 1ns/1ps
module igl_exec_unit_sva (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic cmd_valid_i,
	input wire igl_pkg::igl_cmd_t cmd_i,
	input wire logic busy_o,
	input wire logic mem_req_o,
	input wire logic [31:0] mem_addr_o,
	input wire logic mem_ack_i,
	input wire logic [31:0] mem_rdata_i,
	input wire igl_pkg::igl_wb_t wb_o,
	input wire logic done_o,
	input wire igl_pkg::igl_fault_t fault_o,
	input wire logic irq_mask_o
);
	logic take;
	logic is_gate;
	logic [7:0] op_r;
	logic [31:0] addr_r;
	logic [31:0] rd_r;
	logic bad_dst;

	// a command counts only when the unit is idle
	assign take = cmd_valid_i && !busy_o;
	assign is_gate = cmd_i.opcode == igl_pkg::IGL_OPC_IRQ_CONTROL || cmd_i.opcode == igl_pkg::IGL_OPC_IRQ_DISABLE
		|| cmd_i.opcode == igl_pkg::IGL_OPC_IRQ_ENABLE;
	// destinations that the register alignment rules refuse
	assign bad_dst = (cmd_i.opcode[11:4] == igl_pkg::IGL_OPC_LOAD_DOUBLE_WORD && cmd_i.dst[0])
		|| ((cmd_i.opcode[11:4] == igl_pkg::IGL_OPC_LOAD_TRIPLE_WORD
		|| cmd_i.opcode[11:4] == igl_pkg::IGL_OPC_LOAD_QUAD_WORD) && cmd_i.dst[1:0] != 2'h0);

	// remember load kind, last acked address and data for beat-level checks
	always_ff @(posedge clk_i)
	begin
		if (take)
			op_r <= cmd_i.opcode[11:4];
		if (mem_ack_i)
		begin
			addr_r <= mem_addr_o;
			rd_r <= mem_rdata_i;
		end
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (srst_i);

	a_disable_sets_mask: assert property (
		take && cmd_i.supervisor && cmd_i.opcode == igl_pkg::IGL_OPC_IRQ_DISABLE
		|=> irq_mask_o && busy_o ##1 done_o && !fault_o.valid) else $error("disable did not mask first");
	a_enable_clears_mask: assert property (
		take && cmd_i.supervisor && cmd_i.opcode == igl_pkg::IGL_OPC_IRQ_ENABLE
		|=> !irq_mask_o && busy_o ##1 done_o && !fault_o.valid) else $error("enable did not unmask");
	a_user_gate_fault: assert property (
		take && !cmd_i.supervisor && is_gate |=> done_o && fault_o.valid
		&& fault_o.code == igl_pkg::IGL_FLT_PRIVILEGE && $stable(irq_mask_o) && !wb_o.en)
		else $error("user gate op not refused");
	a_ctl_old_state: assert property (
		take && cmd_i.supervisor && cmd_i.opcode == igl_pkg::IGL_OPC_IRQ_CONTROL
		&& cmd_i.src1 <= igl_pkg::IGL_SRC1_STATUS |=> wb_o.en && wb_o.idx == $past(cmd_i.dst)
		&& wb_o.data == {31'h0, !$past(irq_mask_o)}) else $error("control wrote wrong old state");
	a_ctl_bad_operand: assert property (
		take && cmd_i.supervisor && cmd_i.opcode == igl_pkg::IGL_OPC_IRQ_CONTROL
		&& cmd_i.src1 > igl_pkg::IGL_SRC1_STATUS |=> fault_o.valid && fault_o.code == igl_pkg::IGL_FLT_OPERAND
		&& $stable(irq_mask_o) && !wb_o.en) else $error("bad control operand accepted");
	a_bad_dst_refused: assert property (
		take && bad_dst |=> done_o && fault_o.code == igl_pkg::IGL_FLT_OPERAND && !mem_req_o && !wb_o.en)
		else $error("misaligned destination not refused");
	a_ubyte_zero_fill: assert property (
		mem_ack_i && op_r == igl_pkg::IGL_OPC_LOAD_UBYTE
		|=> wb_o.en && wb_o.data == {24'h000000, rd_r[7:0]}) else $error("unsigned byte not zero filled");
	a_sbyte_sign_fill: assert property (
		mem_ack_i && op_r == igl_pkg::IGL_OPC_LOAD_SBYTE
		|=> wb_o.en && wb_o.data == {{24{rd_r[7]}}, rd_r[7:0]}) else $error("signed byte not sign filled");
	a_beat_addr_step: assert property (
		$rose(mem_req_o) && $past(busy_o)
		|-> mem_addr_o == addr_r + igl_pkg::IGL_WORD_STEP) else $error("next beat address not one word on");
endmodule

bind igl_exec_unit igl_exec_unit_sva chk_u (.clk_i(clk_i), .srst_i(srst_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i),
	.busy_o(busy_o), .mem_req_o(mem_req_o), .mem_addr_o(mem_addr_o), .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i),
	.wb_o(wb_o), .done_o(done_o), .fault_o(fault_o), .irq_mask_o(irq_mask_o));

// >>> tb/igl_mem_model.sv
/*
 * igl_mem_model: read-only memory standing behind the load port.
 * assumes the unit holds mem_req_o until it sees one ack pulse; answer delay set by lat_i.
 */
`timescale 1ns/1ps
module igl_mem_model #(
	parameter logic [31:0] PAT = 32'h8c3a_5e71
) (
	input wire logic clk_i,
	input wire logic req_i,
	input wire logic [31:0] addr_i,
	input wire logic [1:0] lat_i,
	output logic ack_o,
	output logic [31:0] rdata_o
);
	logic [1:0] wait_r;

	initial
	begin
		ack_o = 1'b0;
		rdata_o = 32'h0000_0000;
		wait_r = 2'h0;
	end

	// data bus toggles outside the ack cycle so a stale value is never mistaken for a read
	always @(posedge clk_i)
	begin
		ack_o <= 1'b0;
		rdata_o <= ~rdata_o;
		if (req_i && !ack_o)
		begin
			if (wait_r == lat_i)
			begin
				ack_o <= 1'b1;
				rdata_o <= addr_i ^ PAT;
				wait_r <= 2'h0;
			end
			else
				wait_r <= wait_r + 2'h1;
		end
	end
endmodule

// >>> tb/tb_top.sv
/*
 * tb_top: directed scenarios for the interrupt gate and load unit against a memory model.
 * assumes a 100 MHz clock; inputs change 1 ns after each rising edge.
 */
`timescale 1ns/1ps
module tb_top;
	localparam logic [31:0] PAT = 32'h8c3a_5e71;
	logic clk_i = 1'b0;
	logic srst_i = 1'b1;
	logic cmd_valid_i = 1'b0;
	igl_pkg::igl_cmd_t cmd_i = '0;
	logic busy_o, mem_req_o, mem_ack_i, done_o, irq_mask_o;
	logic [31:0] mem_addr_o, mem_rdata_i;
	igl_pkg::igl_wb_t wb_o;
	igl_pkg::igl_fault_t fault_o;
	igl_pkg::igl_fault_t flt;
	logic [1:0] lat = 2'h0;
	logic [4:0] wb_idx [8];
	logic [31:0] wb_dat [8];
	int nwb, fail_count = 0, num_checks = 0;

	always #5 clk_i = ~clk_i;

	igl_exec_unit dut_u (.clk_i(clk_i), .srst_i(srst_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .busy_o(busy_o),
		.mem_req_o(mem_req_o), .mem_addr_o(mem_addr_o), .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i),
		.wb_o(wb_o), .done_o(done_o), .fault_o(fault_o), .irq_mask_o(irq_mask_o));
	igl_mem_model #(.PAT(PAT)) mem_u (.clk_i(clk_i), .req_i(mem_req_o), .addr_i(mem_addr_o), .lat_i(lat),
		.ack_o(mem_ack_i), .rdata_o(mem_rdata_i));

	task automatic summarize;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	function automatic logic [31:0] fexp(input igl_pkg::igl_fault_code_t c);
		return 32'({c != igl_pkg::IGL_FLT_NONE, c});
	endfunction

	// issue one command for a single cycle, gather register writes until done
	task automatic run(input logic [11:0] opc, input logic [31:0] s1, input logic [4:0] d, input logic [31:0] a,
		input logic sup, input logic ue);
		int n;
		@(posedge clk_i);
		#1;
		cmd_valid_i = 1'b1;
		cmd_i = {opc, s1, d, a, sup, ue};
		@(posedge clk_i);
		#1;
		cmd_valid_i = 1'b0;
		nwb = 0;
		for (n = 0; n < 60 && done_o !== 1'b1; n++)
		begin
			if (wb_o.en === 1'b1 && nwb < 8)
			begin
				wb_idx[nwb] = wb_o.idx;
				wb_dat[nwb] = wb_o.data;
				nwb++;
			end
			@(posedge clk_i);
			#1;
		end
		if (n == 60)
		begin
			fail_count++;
			summarize();
		end
		else
			flt = fault_o;
	endtask

	task automatic t_gate;
		chk("mask_rst", 32'(irq_mask_o), 32'h1);
		run(igl_pkg::IGL_OPC_IRQ_ENABLE, 0, 5'h00, 0, 1'b1, 1'b0);
		chk("mask_en", 32'(irq_mask_o), 32'h0);
		chk("fault_en", 32'(flt), 32'h0);
		run(igl_pkg::IGL_OPC_IRQ_DISABLE, 0, 5'h00, 0, 1'b1, 1'b0);
		chk("mask_dis", 32'(irq_mask_o), 32'h1);
		run(igl_pkg::IGL_OPC_IRQ_ENABLE, 0, 5'h00, 0, 1'b0, 1'b0);
		chk("user_fault", 32'(flt), fexp(igl_pkg::IGL_FLT_PRIVILEGE));
		chk("user_mask", 32'(irq_mask_o), 32'h1);
		$display("test gate finished");
	endtask

	// starts disabled: status, enable, disable, then an illegal operand
	task automatic t_ctl;
		logic [31:0] s1s [4] = '{32'h2, 32'h1, 32'h0, 32'h3};
		logic en = 1'b0;
		for (int i = 0; i < 4; i++)
		begin
			run(igl_pkg::IGL_OPC_IRQ_CONTROL, s1s[i], 5'h07, 0, 1'b1, 1'b0);
			if (s1s[i] == 32'h3)
			begin
				chk("ctl_fault", 32'(flt), fexp(igl_pkg::IGL_FLT_OPERAND));
				chk("ctl_nwb", 32'(nwb), 32'h0);
				chk("ctl_keep", 32'(irq_mask_o), 32'(!en));
			end
			else
			begin
				chk("ctl_nwb1", 32'(nwb), 32'h1);
				chk("ctl_old", wb_dat[0], 32'(en));
				chk("ctl_idx", 32'(wb_idx[0]), 32'h7);
				if (s1s[i] != 32'h2)
					en = s1s[i][0];
				chk("ctl_mask", 32'(irq_mask_o), 32'(!en));
			end
		end
		$display("test control finished");
	endtask

	task automatic t_ext;
		logic [7:0] ops [6] = '{igl_pkg::IGL_OPC_LOAD_UBYTE, igl_pkg::IGL_OPC_LOAD_SBYTE, igl_pkg::IGL_OPC_LOAD_SBYTE,
			igl_pkg::IGL_OPC_LOAD_UHALF, igl_pkg::IGL_OPC_LOAD_SHALF, igl_pkg::IGL_OPC_LOAD_SHALF};
		logic [31:0] ads [6] = '{32'h80, 32'h80, 32'h0, 32'h8000, 32'h8000, 32'h0};
		logic [31:0] exp [6] = '{32'h0000_00f1, 32'hffff_fff1, 32'h0000_0071, 32'h0000_de71, 32'hffff_de71, 32'h0000_5e71};
		for (int i = 0; i < 6; i++)
		begin
			run({ops[i], 4'h0}, 0, 5'h05, ads[i], 1'b1, 1'b1);
			chk("ext_data", wb_dat[0], exp[i]);
			chk("ext_idx", 32'(wb_idx[0]), 32'h5);
		end
		$display("test extend finished");
	endtask

	// word to quad at slower and slower memory, then refused destinations
	task automatic t_multi;
		logic [7:0] ops [4] = '{igl_pkg::IGL_OPC_LOAD_SINGLE_WORD, igl_pkg::IGL_OPC_LOAD_DOUBLE_WORD,
			igl_pkg::IGL_OPC_LOAD_TRIPLE_WORD, igl_pkg::IGL_OPC_LOAD_QUAD_WORD};
		for (int i = 0; i < 4; i++)
		begin
			lat = 2'(i);
			run({ops[i], 4'h0}, 0, 5'd12, 32'h200, 1'b1, 1'b1);
			chk("beats", 32'(nwb), 32'(i + 1));
			for (int k = 0; k <= i; k++)
			begin
				chk("beat_idx", 32'(wb_idx[k]), 32'(12 + k));
				chk("beat_data", wb_dat[k], (32'h200 + 32'(4 * k)) ^ PAT);
			end
		end
		run({igl_pkg::IGL_OPC_LOAD_DOUBLE_WORD, 4'h0}, 0, 5'd11, 32'h200, 1'b1, 1'b0);
		chk("dbl_odd", 32'(flt), fexp(igl_pkg::IGL_FLT_OPERAND));
		run({igl_pkg::IGL_OPC_LOAD_QUAD_WORD, 4'h0}, 0, 5'd14, 32'h200, 1'b1, 1'b0);
		chk("quad_dst", 32'(flt), fexp(igl_pkg::IGL_FLT_OPERAND));
		chk("quad_nwb", 32'(nwb), 32'h0);
		$display("test multi finished");
	endtask

	task automatic t_unal;
		logic [7:0] ops [7] = '{igl_pkg::IGL_OPC_LOAD_SINGLE_WORD, igl_pkg::IGL_OPC_LOAD_SINGLE_WORD,
			igl_pkg::IGL_OPC_LOAD_DOUBLE_WORD, igl_pkg::IGL_OPC_LOAD_QUAD_WORD, igl_pkg::IGL_OPC_LOAD_TRIPLE_WORD,
			igl_pkg::IGL_OPC_LOAD_UHALF, 8'h00};
		logic [31:0] ads [7] = '{32'h202, 32'h202, 32'h204, 32'h208, 32'h210, 32'h201, 32'h200};
		logic ens [7] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
		logic [31:0] exp [7] = '{fexp(igl_pkg::IGL_FLT_UNALIGNED), 32'h0, fexp(igl_pkg::IGL_FLT_UNALIGNED),
			fexp(igl_pkg::IGL_FLT_UNALIGNED), 32'h0, fexp(igl_pkg::IGL_FLT_UNALIGNED), fexp(igl_pkg::IGL_FLT_OPCODE)};
		lat = 2'h0;
		for (int i = 0; i < 7; i++)
		begin
			run({ops[i], 4'h0}, 0, 5'd8, ads[i], 1'b1, ens[i]);
			chk("unal_fault", 32'(flt), exp[i]);
		end
		$display("test unaligned finished");
	endtask

	// reset held three cycles, then every scenario in turn
	initial
	begin
		repeat (3) @(posedge clk_i);
		#1;
		srst_i = 1'b0;
		t_gate();
		t_ctl();
		t_ext();
		t_multi();
		t_unal();
		summarize();
	end
endmodule
